// *** hdl/pin_remap_pkg.sv ***
// package: register map, field layout and types for the pin remap block
package pin_remap_pkg;

   // ==========================================================
   // geometry
   localparam int NUM_IN_REGS   = 20;
   localparam int NUM_OUT_REGS  = 13;
   localparam int NUM_PINS      = 26;
   localparam int SEL_W         = 5;
   localparam int REG_W         = 16;
   localparam int ADDR_W        = 6;

   // ==========================================================
   // register offsets (word index on the plain port)
   localparam logic [ADDR_W-1:0] IN_BASE   = 6'h00;
   localparam logic [ADDR_W-1:0] OUT_BASE  = 6'h14;
   localparam logic [ADDR_W-1:0] LOCK_ADDR = 6'h21;

   // ==========================================================
   // field layout
   localparam int SEL_HI_LSB = 8;
   localparam int SEL_LO_LSB = 0;
   localparam int LOCK_BIT   = 0;
   localparam logic [SEL_W-1:0] SEL_GND   = 5'h1f;
   localparam logic [SEL_W-1:0] SEL_MAXPIN = 5'h19;
   localparam logic [REG_W-1:0] IN_RESET  = 16'h1f1f;
   localparam logic [REG_W-1:0] IN_MASK   = 16'h1f1f;
   // first input register: interrupt selector only, low byte unimplemented
   localparam logic [REG_W-1:0] REG0_RESET = 16'h1f00;
   localparam logic [REG_W-1:0] REG0_MASK  = 16'h1f00;
   localparam logic [REG_W-1:0] OUT_RESET = 16'h0000;
   localparam logic [REG_W-1:0] OUT_MASK  = 16'h1f1f;

   // register bus request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
   } reg_req_s;

endpackage

// *** hdl/remap_reg_bank.sv ***
// register bank: input and output remap registers with lock gating
module remap_reg_bank
   import pin_remap_pkg::*;
#(
   parameter int N_REGS = NUM_IN_REGS,
   parameter logic [ADDR_W-1:0] BASE = IN_BASE,
   parameter logic [REG_W-1:0]  RST = IN_RESET,
   parameter logic [REG_W-1:0]  MASK = IN_MASK
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   // bus side
   input  wire reg_req_s               req,
   input  wire logic                   locked,
   // register contents
   output logic [N_REGS-1:0][REG_W-1:0] regs_q
);
   // ==========================================================
   // per register write decode and storage
   for (genvar i = 0; i < N_REGS; i++) begin : g_reg
      // the first input register keeps only its interrupt selector field
      localparam bit               FIRST = (BASE == IN_BASE) && (i == 0);
      localparam logic [REG_W-1:0] KEEP  = FIRST ? REG0_MASK : MASK;
      localparam logic [REG_W-1:0] INIT  = FIRST ? REG0_RESET : RST;
      wire hit = req.wr && !locked && (req.addr == BASE + ADDR_W'(i));
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            regs_q[i] <= INIT;
         end else if (hit) begin
            regs_q[i] <= req.wdata & KEEP;
         end
      end
   end
endmodule

// *** hdl/remap_sel_mux.sv ***
// one selector: pin index or ground onto a peripheral input
module remap_sel_mux
   import pin_remap_pkg::*;
#(
   parameter int N_PINS = NUM_PINS
) (
   // selection
   input  wire logic [SEL_W-1:0]  sel,
   input  wire logic [N_PINS-1:0] pins,
   // result
   output logic                   y
);
   // ==========================================================
   // codes 0..N_PINS-1 pick that pin; ground code and others give 0
   wire in_range = (32'(sel) < N_PINS);
   wire is_gnd   = (sel == SEL_GND);
   assign y = (in_range && !is_gnd) ? pins[sel] : 1'b0;
endmodule

// *** hdl/peripheral_input_pin_remap.sv ***
// top: peripheral pin remap with register port and lock
//
// Chosen here: the address-and-strobe port and the register addresses.
module peripheral_input_pin_remap
   import pin_remap_pkg::*;
#(
   parameter int N_PINS = NUM_PINS
) (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rstn,
   // register port
   input  wire logic [ADDR_W-1:0]            addr,
   input  wire logic [REG_W-1:0]             wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [REG_W-1:0]             rdata,
   // pins in, peripheral inputs out (two per input register)
   input  wire logic [N_PINS-1:0]            pin_in,
   output logic      [2*NUM_IN_REGS-1:0]     periph_in,
   output logic                              ext_int1_in,
   // pin drive codes out, two per output register
   output logic      [2*NUM_OUT_REGS-1:0][SEL_W-1:0] pin_out_sel,
   // lock state
   output logic                              pin_config_lock
);
   // ==========================================================
   // bus request bundle and lock register
   reg_req_s req;
   logic     lock_q;
   logic     lock_d;
   assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
   wire   lock_hit = wr && (addr == LOCK_ADDR);
   assign lock_d = lock_hit ? wdata[LOCK_BIT] : lock_q;
   assign pin_config_lock = lock_q;

   // lock bit, cleared after reset so software can configure
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
      end
   end

   // ==========================================================
   // register banks
   logic [NUM_IN_REGS-1:0][REG_W-1:0]  in_regs;
   logic [NUM_OUT_REGS-1:0][REG_W-1:0] out_regs;

   remap_reg_bank #(
      .N_REGS (NUM_IN_REGS),
      .BASE   (IN_BASE),
      .RST    (IN_RESET),
      .MASK   (IN_MASK)
   ) u_in_bank (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .req     (req),
      .locked  (lock_q),
      .regs_q  (in_regs)
   );

   remap_reg_bank #(
      .N_REGS (NUM_OUT_REGS),
      .BASE   (OUT_BASE),
      .RST    (OUT_RESET),
      .MASK   (OUT_MASK)
   ) u_out_bank (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .req     (req),
      .locked  (lock_q),
      .regs_q  (out_regs)
   );

   // ==========================================================
   // input selectors: high field of each register, low field of each register but the first
   logic [2*NUM_IN_REGS-1:0] periph_d;
   for (genvar i = 0; i < NUM_IN_REGS; i++) begin : g_in
      remap_sel_mux #(.N_PINS(N_PINS)) u_hi (
         .sel  (in_regs[i][SEL_HI_LSB +: SEL_W]),
         .pins (pin_in),
         .y    (periph_d[2*i+1])
      );
      // the first register has no second selector, its partner input stays grounded
      remap_sel_mux #(.N_PINS(N_PINS)) u_lo (
         .sel  ((i == 0) ? SEL_GND : in_regs[i][SEL_LO_LSB +: SEL_W]),
         .pins (pin_in),
         .y    (periph_d[2*i])
      );
   end

   // registered peripheral inputs, ground at reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         periph_in <= '0;
      end else begin
         periph_in <= periph_d;
      end
   end
   assign ext_int1_in = periph_in[1];

   // ==========================================================
   // output selector codes, registered
   for (genvar j = 0; j < NUM_OUT_REGS; j++) begin : g_out
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            pin_out_sel[2*j+1] <= '0;
            pin_out_sel[2*j]   <= '0;
         end else begin
            pin_out_sel[2*j+1] <= out_regs[j][SEL_HI_LSB +: SEL_W];
            pin_out_sel[2*j]   <= out_regs[j][SEL_LO_LSB +: SEL_W];
         end
      end
   end

   // ==========================================================
   // read decode, data one cycle after the strobe
   wire in_rd  = (addr >= IN_BASE) && (addr < IN_BASE + ADDR_W'(NUM_IN_REGS));
   wire out_rd = (addr >= OUT_BASE) && (addr < OUT_BASE + ADDR_W'(NUM_OUT_REGS));
   wire [ADDR_W-1:0] in_idx  = addr - IN_BASE;
   wire [ADDR_W-1:0] out_idx = addr - OUT_BASE;
   logic [REG_W-1:0] rdata_d;
   assign rdata_d = !rd                  ? '0 :
                    in_rd                ? in_regs[in_idx[4:0]] :
                    out_rd               ? out_regs[out_idx[3:0]] :
                    (addr == LOCK_ADDR)  ? {{(REG_W-1){1'b0}}, lock_q} :
                                           '0; // unmapped reads zero

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else begin
         rdata <= rdata_d;
      end
   end

   // ==========================================================
   // checks
   sequence s_int1_write;
      wr && !lock_q && addr == IN_BASE;
   endsequence

   property p_int1_field;
      @(posedge ref_clk) disable iff (!rstn)
         s_int1_write |=> in_regs[0][12:8] == $past(wdata[12:8]);
   endproperty
   a_int1_field: assert property (p_int1_field) else $error("int1 field not stored");

   property p_unused_zero;
      @(posedge ref_clk) disable iff (!rstn)
         rd && addr == IN_BASE |=> (rdata & ~REG0_MASK) == 16'h0000;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

   property p_lock_hold;
      @(posedge ref_clk) disable iff (!rstn)
         wr && lock_q && addr == IN_BASE |=> $stable(in_regs[0]);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("write passed lock");

   property p_out_lock;
      @(posedge ref_clk) disable iff (!rstn)
         wr && lock_q && addr == OUT_BASE |=> $stable(out_regs[0]);
   endproperty
   a_out_lock: assert property (p_out_lock) else $error("output write passed lock");

   property p_gnd;
      @(posedge ref_clk) disable iff (!rstn)
         in_regs[0][12:8] == SEL_GND |=> !ext_int1_in;
   endproperty
   a_gnd: assert property (p_gnd) else $error("ground code not low");

   property p_pin_sel;
      @(posedge ref_clk) disable iff (!rstn)
         in_regs[0][12:8] <= SEL_MAXPIN |=> ext_int1_in == $past(pin_in[in_regs[0][12:8]]);
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("wrong pin routed");

   // ==========================================================
   // reach: a write then a read at the last index of each bank
   wire [ADDR_W-1:0] last_in_addr  = IN_BASE + ADDR_W'(NUM_IN_REGS - 1);
   wire [ADDR_W-1:0] last_out_addr = OUT_BASE + ADDR_W'(NUM_OUT_REGS - 1);

   sequence s_last_in_write;
      wr && !lock_q && addr == last_in_addr;
   endsequence

   sequence s_last_in_read;
      rd && addr == last_in_addr;
   endsequence

   sequence s_last_out_write;
      wr && !lock_q && addr == last_out_addr;
   endsequence

   sequence s_last_out_read;
      rd && addr == last_out_addr;
   endsequence

   property p_in_count;
      @(posedge ref_clk) disable iff (!rstn)
         s_last_in_write ##1 s_last_in_read |=> rdata == ($past(wdata, 2) & IN_MASK);
   endproperty
   a_in_count: assert property (p_in_count) else $error("last input reg missing");

   property p_out_count;
      @(posedge ref_clk) disable iff (!rstn)
         s_last_out_write ##1 s_last_out_read |=> rdata == ($past(wdata, 2) & OUT_MASK);
   endproperty
   a_out_count: assert property (p_out_count) else $error("last output reg missing");

   // ==========================================================
   // unused bits of the interrupt register stay zero
   property p_int1_unused;
      @(posedge ref_clk) disable iff (!rstn)
         s_int1_write |=> in_regs[0][15:13] == 3'h0 && in_regs[0][7:0] == 8'h00;
   endproperty
   a_int1_unused: assert property (p_int1_unused) else $error("unused bits written");

   property p_no_partner;
      @(posedge ref_clk) disable iff (!rstn)
         1'b1 |=> !periph_in[0];
   endproperty
   a_no_partner: assert property (p_no_partner) else $error("phantom input driven");

   // ==========================================================
   // lock bit: stored on its own write, otherwise steady
   sequence s_lock_write;
      wr && addr == LOCK_ADDR;
   endsequence

   property p_lock_set;
      @(posedge ref_clk) disable iff (!rstn)
         s_lock_write |=> pin_config_lock == $past(wdata[LOCK_BIT]);
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock bit not stored");

   property p_lock_keep;
      @(posedge ref_clk) disable iff (!rstn)
         !(wr && addr == LOCK_ADDR) |=> $stable(pin_config_lock);
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("lock bit moved");

   property p_lock_last;
      @(posedge ref_clk) disable iff (!rstn)
         wr && lock_q && addr == last_in_addr |=> $stable(in_regs[NUM_IN_REGS-1]);
   endproperty
   a_lock_last: assert property (p_lock_last) else $error("last reg passed lock");

   // ==========================================================
   // selector decode for a high field and a low field
   property p_hi_gnd;
      @(posedge ref_clk) disable iff (!rstn)
         in_regs[0][12:8] > SEL_MAXPIN |=> !ext_int1_in;
   endproperty
   a_hi_gnd: assert property (p_hi_gnd) else $error("code past last pin not low");

   property p_lo_sel;
      @(posedge ref_clk) disable iff (!rstn)
         in_regs[1][4:0] <= SEL_MAXPIN |=> periph_in[2] == $past(pin_in[in_regs[1][4:0]]);
   endproperty
   a_lo_sel: assert property (p_lo_sel) else $error("low field wrong pin");

   property p_lo_gnd;
      @(posedge ref_clk) disable iff (!rstn)
         in_regs[1][4:0] == SEL_GND |=> !periph_in[2];
   endproperty
   a_lo_gnd: assert property (p_lo_gnd) else $error("low field ground not low");

   // ==========================================================
   // read path and output codes
   property p_rd_in;
      @(posedge ref_clk) disable iff (!rstn)
         rd && in_rd |=> rdata == $past(in_regs[in_idx[4:0]]);
   endproperty
   a_rd_in: assert property (p_rd_in) else $error("input reg read wrong");

   property p_rd_out;
      @(posedge ref_clk) disable iff (!rstn)
         rd && out_rd |=> rdata == $past(out_regs[out_idx[3:0]]);
   endproperty
   a_rd_out: assert property (p_rd_out) else $error("output reg read wrong");

   property p_rd_idle;
      @(posedge ref_clk) disable iff (!rstn)
         !rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");

   property p_out_hi;
      @(posedge ref_clk) disable iff (!rstn)
         1'b1 |=> pin_out_sel[2*NUM_OUT_REGS-1] == $past(out_regs[NUM_OUT_REGS-1][12:8]);
   endproperty
   a_out_hi: assert property (p_out_hi) else $error("output high code wrong");

   property p_out_lo;
      @(posedge ref_clk) disable iff (!rstn)
         1'b1 |=> pin_out_sel[0] == $past(out_regs[0][4:0]);
   endproperty
   a_out_lo: assert property (p_out_lo) else $error("output low code wrong");
endmodule

// *** testbench/pin_side_model.sv ***
// behavioural pin side: one pin differs from all the others while hot_idx names a pin
module pin_side_model
   import pin_remap_pkg::*;
(
   // pattern control
   input  wire logic [SEL_W-1:0]    hot_idx,
   input  wire logic                invert,
   // remappable pin levels
   output logic      [NUM_PINS-1:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================================
   // pattern: index past the last pin leaves all pins alike
   assign pins = ({{(NUM_PINS-1){1'b0}}, 1'b1} << hot_idx) ^ {NUM_PINS{invert}};
endmodule

// *** testbench/tb.sv ***
// testbench: register port, selector sweep, ground code, banks, lock
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb
   import pin_remap_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                                  ref_clk, rstn, wr, rd, invert;
   logic [ADDR_W-1:0]                     addr;
   logic [REG_W-1:0]                      wdata, rdata, rv;
   logic [NUM_PINS-1:0]                   pin_in;
   logic [2*NUM_IN_REGS-1:0]              periph_in;
   logic                                  ext_int1_in, pin_config_lock;
   logic [2*NUM_OUT_REGS-1:0][SEL_W-1:0]  pin_out_sel;
   logic [SEL_W-1:0]                      hot_idx;
   int                                    err_total, samples_checked;
   // =====================================================
   // design, pin model, clock
   peripheral_input_pin_remap u_peripheral_input_pin_remap (.ref_clk(ref_clk), .rstn(rstn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
      .periph_in(periph_in), .ext_int1_in(ext_int1_in), .pin_out_sel(pin_out_sel),
      .pin_config_lock(pin_config_lock));
   pin_side_model u_pin_side_model (.hot_idx(hot_idx), .invert(invert), .pins(pin_in));
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;
   // =====================================================
   // bus cycles, one-cycle strobes
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge ref_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge ref_clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
      @(posedge ref_clk) begin rd <= 1'b1; addr <= a; end
      @(posedge ref_clk) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wr_rd_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
                            output logic [REG_W-1:0] q);
      @(posedge ref_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge ref_clk) begin wr <= 1'b0; rd <= 1'b1; end
      @(posedge ref_clk) rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   // =====================================================
   // scenarios
   task automatic t_reset;
      #1 `CHK("periph_in", 40'h0, periph_in)
      `CHK("lock", 1'b0, pin_config_lock)
      rd_reg(IN_BASE, rv);
      `CHK("reg0 reset", 16'h1f00, rv)
      rd_reg(OUT_BASE, rv);
      `CHK("out0 reset", 16'h0000, rv)
   endtask
   task automatic t_codes;
      for (int c = 0; c < NUM_PINS; c++) begin
         wr_reg(IN_BASE, 16'(c) << 8);
         hot_idx <= 5'(c);
         invert <= 1'b0;
         settle();
         `CHK("int1 high", 1'b1, ext_int1_in)
         `CHK("periph1", 1'b1, periph_in[1])
         @(posedge ref_clk) invert <= 1'b1;
         settle();
         `CHK("int1 low", 1'b0, ext_int1_in)
      end
   endtask
   task automatic t_ground;
      wr_reg(IN_BASE, 16'hffff);
      hot_idx <= 5'h1f;
      invert <= 1'b1;
      settle();
      `CHK("gnd int1", 1'b0, ext_int1_in)
      `CHK("gnd low", 1'b0, periph_in[0])
      rd_reg(IN_BASE, rv);
      `CHK("unused bits", 16'h1f00, rv)
      wr_reg(IN_BASE, 16'h1a00);
      settle();
      `CHK("code 26 int1", 1'b0, ext_int1_in)
   endtask
   task automatic t_banks;
      logic [REG_W-1:0] v;
      for (int i = 0; i < NUM_IN_REGS; i++) begin
         v = {3'h0, 5'(i), 3'h0, 5'(i + 1)};
         wr_rd_reg(IN_BASE + 6'(i), v, rv);
         `CHK("in reg", v & ((i == 0) ? REG0_MASK : IN_MASK), rv)
         @(posedge ref_clk) begin hot_idx <= 5'(i + 1); invert <= 1'b0; end
         settle();
         `CHK("periph hi", 1'b0, periph_in[2*i+1])
         `CHK("periph lo", (i > 0), periph_in[2*i])
      end
      for (int j = 0; j < NUM_OUT_REGS; j++) begin
         v = {3'h0, 5'(j + 3), 3'h0, 5'(j)};
         wr_rd_reg(OUT_BASE + 6'(j), v, rv);
         `CHK("out reg", v & OUT_MASK, rv)
         settle();
         `CHK("out hi", 5'(j + 3), pin_out_sel[2*j+1])
         `CHK("out lo", 5'(j), pin_out_sel[2*j])
      end
      rd_reg(6'h3f, rv);
      `CHK("unmapped", 16'h0000, rv)
   endtask
   task automatic t_lock;
      wr_reg(LOCK_ADDR, 16'h0001);
      wr_reg(IN_BASE, 16'h0500);
      wr_reg(OUT_BASE, 16'h0707);
      wr_reg(IN_BASE + 6'h13, 16'h0202);
      #1 `CHK("locked", 1'b1, pin_config_lock)
      rd_reg(IN_BASE, rv);
      `CHK("in held", 16'h0000, rv)
      rd_reg(OUT_BASE, rv);
      `CHK("out held", 16'h0300, rv)
      rd_reg(IN_BASE + 6'h13, rv);
      `CHK("last held", 16'h1314, rv)
      wr_reg(LOCK_ADDR, 16'h0000);
      wr_reg(IN_BASE, 16'h0500);
      rd_reg(IN_BASE, rv);
      `CHK("in open", 16'h0500, rv)
   endtask
   // =====================================================
   // verdict, watchdog, main sequence
   task automatic print_verdict;
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #(25 * 5000);
      err_total++;
      print_verdict();
   end
   initial begin
      err_total = 0;
      samples_checked = 0;
      rstn = 1'b0;
      {wr, rd, addr, wdata} = '0;
      hot_idx = 5'h1f;
      invert = 1'b1;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset();
      t_codes();
      t_ground();
      t_banks();
      t_lock();
      print_verdict();
   end
endmodule
